// File: verilog/psa_pkg.sv
// Package with operation codes, widths and field constants of the packed SIMD ALU
package psa_pkg;
  localparam int unsigned psa_wide_width = 128;
  localparam int unsigned psa_half_width = 64;
  localparam int unsigned psa_byte_count = 16;
  localparam int unsigned psa_shift_max = 15;
  localparam int unsigned psa_byte_bits = 8;
  localparam int unsigned psa_shift_cnt_bits = 4;
  localparam logic [7:0] psa_shift_max_imm = 8'h0f;
  localparam logic [15:0] psa_avg_carry_in = 16'h0001;

  typedef enum logic [3:0] {
    psa_op_sum_abs_diff,
    psa_op_avg_byte,
    psa_op_avg_word,
    psa_op_mul_add_pairs,
    psa_op_dword_unsigned_widen_multiply,
    psa_op_quad_lane_add,
    psa_op_quad_lane_subtract,
    psa_op_byte_shift_left,
    psa_op_byte_shift_right,
    psa_op_pass
  } psa_op_type;
endpackage

// File: verilog/psa_lane_if.sv
// Interface carrying one 64-bit lane request and result between the top and the lane module
`timescale 1ns/100ps
`default_nettype none
interface psa_lane_if;
  import psa_pkg::*;
  psa_op_type op;
  logic [63:0] dst;
  logic [63:0] src;
  logic [63:0] res;
  modport top (output op, output dst, output src, input res);
  modport lane (input op, input dst, input src, output res);
endinterface
`default_nettype wire

// File: verilog/psa_lane.sv
// One 64-bit lane of the packed SIMD ALU: all element-wise operations
`timescale 1ns/100ps
`default_nettype none
module psa_lane (
  // Lane request and result
  psa_lane_if.lane lane
);
  import psa_pkg::*;

  logic [63:0] sad_res;
  logic [63:0] avgb_res;
  logic [63:0] avgw_res;
  logic [63:0] madd_res;
  logic [63:0] mul_res;
  logic [15:0] sad_sum;
  logic [7:0] diff [8];
  logic signed [31:0] prod [4];

  // ----------------------------------------
  // Element-wise stages
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_byte
      logic [7:0] a;
      logic [7:0] b;
      logic [8:0] s;
      assign a = lane.dst[gi*8 +: 8];
      assign b = lane.src[gi*8 +: 8];
      assign diff[gi] = (a > b) ? a - b : b - a;
      assign s = {1'b0, a} + {1'b0, b} + {8'h00, psa_avg_carry_in[0]};
      assign avgb_res[gi*8 +: 8] = s[8:1];
    end
    for (gi = 0; gi < 4; gi++) begin : g_word
      logic [16:0] s;
      assign s = {1'b0, lane.dst[gi*16 +: 16]} + {1'b0, lane.src[gi*16 +: 16]} + {1'b0, psa_avg_carry_in};
      assign avgw_res[gi*16 +: 16] = s[16:1];
      assign prod[gi] = $signed(lane.dst[gi*16 +: 16]) * $signed(lane.src[gi*16 +: 16]);
    end
  endgenerate

  always_comb begin
    sad_sum = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      sad_sum = sad_sum + {8'h00, diff[i]};
    end
  end

  assign sad_res = {48'h0, sad_sum};
  assign madd_res = {32'(prod[3] + prod[2]), 32'(prod[1] + prod[0])};
  assign mul_res = {32'h0, lane.dst[31:0]} * {32'h0, lane.src[31:0]};

  // ----------------------------------------
  // Result select
  // ----------------------------------------
  always_comb begin
    case (lane.op)
      psa_op_sum_abs_diff: lane.res = sad_res;
      psa_op_avg_byte: lane.res = avgb_res;
      psa_op_avg_word: lane.res = avgw_res;
      psa_op_mul_add_pairs: lane.res = madd_res;
      psa_op_dword_unsigned_widen_multiply: lane.res = mul_res;
      psa_op_quad_lane_add: lane.res = lane.dst + lane.src;
      psa_op_quad_lane_subtract: lane.res = lane.dst - lane.src;
      default: lane.res = lane.dst;
    endcase
  end
endmodule
`default_nettype wire

// File: verilog/psa_alu.sv
// Top of the packed integer SIMD ALU: operand select, two lanes, byte shifts, result register
// Operation
// - Sum of absolute byte differences goes to low 16 bits of each 64-bit chunk, upper words of the chunk zero.
// - Average adds elements plus carry-in, shifts right, carry-out into top bit.
// - Average has a byte variant and a word variant, both unsigned.
// - Multiply-add: signed 16-bit products, adjacent pairs summed into 32-bit results.
// - Unsigned multiply of low dword per 64-bit chunk, full 64-bit product.
// - Multiply and quad add/subtract exist in 64-bit and 128-bit forms.
// - Quad add/subtract per 64-bit chunk, wrapping without saturation.
// - Quad add/subtract serve signed and unsigned operands with identical logic.
// - Whole-register byte shifts by immediate count, zero fill.
// - Byte shift count above 15 clears the whole destination.
`timescale 1ns/100ps
`default_nettype none
module psa_alu (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Issue
  input wire logic issue_valid,
  input wire psa_pkg::psa_op_type issue_op,
  input wire logic issue_wide,
  input wire logic issue_src_is_mem,
  input wire logic [7:0] issue_imm,
  // Operands
  input wire logic [127:0] dst_reg_value,
  input wire logic [127:0] src_reg_value,
  input wire logic [127:0] src_mem_value,
  // Result
  output logic result_valid,
  output logic [127:0] result_value
);
  import psa_pkg::*;

  localparam int unsigned lane_count = psa_wide_width / psa_half_width;
  localparam int unsigned byte_index_bits = psa_shift_cnt_bits + 1;

  // Decoded request
  logic issue_taken;
  logic sel_shift;
  logic shift_left;
  logic shift_in_range;
  logic upper_lane_on;
  logic [psa_shift_cnt_bits-1:0] shift_bytes;

  // Operands
  logic [psa_wide_width-1:0] src_sel;
  logic [psa_byte_bits-1:0] dst_bytes [psa_byte_count];

  // Unit results
  logic [psa_half_width-1:0] lane_out [lane_count];
  logic [psa_wide_width-1:0] lane_res;
  logic [psa_wide_width-1:0] shift_res;
  logic [psa_wide_width-1:0] unit_res;

  // Result state
  logic valid_d;
  logic valid_q;
  logic [psa_wide_width-1:0] result_d;
  logic [psa_wide_width-1:0] result_q;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  // A request is taken on every edge where it is valid; there is no back-pressure
  assign issue_taken = issue_valid;

  // Only the two shift codes leave the lane datapath
  always_comb begin
    sel_shift = 1'b0;
    shift_left = 1'b0;

    case (issue_op)
      psa_op_byte_shift_left: begin
        sel_shift = 1'b1;
        shift_left = 1'b1;
      end
      psa_op_byte_shift_right: begin
        sel_shift = 1'b1;
        shift_left = 1'b0;
      end
      psa_op_sum_abs_diff,
      psa_op_avg_byte,
      psa_op_avg_word,
      psa_op_mul_add_pairs,
      psa_op_dword_unsigned_widen_multiply,
      psa_op_quad_lane_add,
      psa_op_quad_lane_subtract,
      psa_op_pass: begin
        sel_shift = 1'b0;
        shift_left = 1'b0;
      end
      default: begin
        sel_shift = 1'b0;
        shift_left = 1'b0;
      end
    endcase
  end

  // Counts above the largest byte index clear the whole register
  assign shift_in_range = issue_imm <= psa_shift_max_imm;
  assign shift_bytes = issue_imm[psa_shift_cnt_bits-1:0];
  // Byte shifts always span the whole register; the width choice only reaches lane operations
  assign upper_lane_on = issue_wide;

  // ----------------------------------------
  // Operand select
  // ----------------------------------------
  // The destination is always the register operand; only the second source may come from memory
  assign src_sel = issue_src_is_mem ? src_mem_value : src_reg_value;

  // ----------------------------------------
  // Lanes
  // ----------------------------------------
  // Each 64-bit lane works on its own; no carry or data passes between lanes
  genvar gl;
  generate
    for (gl = 0; gl < lane_count; gl++) begin : g_lane
      psa_lane_if lane_bus ();
      assign lane_bus.op = issue_op;
      assign lane_bus.dst = dst_reg_value[gl*psa_half_width +: psa_half_width];
      assign lane_bus.src = src_sel[gl*psa_half_width +: psa_half_width];

      psa_lane u_lane (
        .lane(lane_bus.lane)
      );
      assign lane_out[gl] = lane_bus.res;

      // The narrow form keeps every lane above the lowest at zero
      if (gl == 0) begin : g_low
        assign lane_res[gl*psa_half_width +: psa_half_width] = lane_out[gl];
      end else begin : g_high
        assign lane_res[gl*psa_half_width +: psa_half_width] = upper_lane_on ? lane_out[gl] : '0;
      end
    end
  endgenerate

  // ----------------------------------------
  // Whole-register byte shifts
  // ----------------------------------------
  // Each result byte picks its source byte directly, so vacated bytes come out as zero
  genvar gb;
  generate
    for (gb = 0; gb < psa_byte_count; gb++) begin : g_shift_byte
      logic [byte_index_bits-1:0] from_low;
      logic [byte_index_bits-1:0] from_high;
      logic low_ok;
      logic high_ok;
      logic [psa_byte_bits-1:0] left_byte;
      logic [psa_byte_bits-1:0] right_byte;

      assign dst_bytes[gb] = dst_reg_value[gb*psa_byte_bits +: psa_byte_bits];
      assign from_low = byte_index_bits'(gb) - {1'b0, shift_bytes};
      assign from_high = byte_index_bits'(gb) + {1'b0, shift_bytes};
      assign low_ok = {1'b0, shift_bytes} <= byte_index_bits'(gb);
      assign high_ok = from_high <= byte_index_bits'(psa_shift_max);

      assign left_byte = low_ok
        ? dst_bytes[from_low[psa_shift_cnt_bits-1:0]] : '0;
      assign right_byte = high_ok
        ? dst_bytes[from_high[psa_shift_cnt_bits-1:0]] : '0;
      assign shift_res[gb*psa_byte_bits +: psa_byte_bits] = shift_in_range
        ? (shift_left ? left_byte : right_byte) : '0;
    end
  endgenerate

  // ----------------------------------------
  // Result select
  // ----------------------------------------
  // Shifts read the full register; everything else takes the lanes
  always_comb begin
    unit_res = lane_res;
    if (sel_shift) begin
      unit_res = shift_res;
    end
  end

  // ----------------------------------------
  // Result valid
  // ----------------------------------------
  // One pulse per request, one cycle after it is taken
  always_comb begin
    valid_d = issue_taken;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  // ----------------------------------------
  // Result value
  // ----------------------------------------
  // Loads only on a request and holds the last result otherwise
  always_comb begin
    result_d = result_q;
    if (issue_taken) begin
      result_d = unit_res;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_q <= '0;
    end else begin
      result_q <= result_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign result_valid = valid_q;
  assign result_value = result_q;
endmodule
`default_nettype wire

// File: tb/psa_pipe_model.sv
// Pipeline model supplying the second operand from a register or memory
`timescale 1ns/100ps
`default_nettype none
module psa_pipe_model (
  // Operand request
  input wire logic use_mem,
  input wire logic [127:0] operand,
  // Operand candidates
  output logic [127:0] src_reg_value,
  output logic [127:0] src_mem_value
);
  // The unused candidate carries the inverse so a wrong pick shows
  assign src_mem_value = use_mem ? operand : ~operand;
  assign src_reg_value = use_mem ? ~operand : operand;
endmodule
`default_nettype wire

// File: tb/psa_alu_sva.sv
// Port checker of the packed SIMD ALU
`timescale 1ns/100ps
`default_nettype none
module psa_alu_sva (
  // Clock, issue, operands, result
  input wire logic clock,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire psa_pkg::psa_op_type issue_op,
  input wire logic issue_wide,
  input wire logic issue_src_is_mem,
  input wire logic [7:0] issue_imm,
  input wire logic [127:0] dst_reg_value,
  input wire logic [127:0] src_reg_value,
  input wire logic [127:0] src_mem_value,
  input wire logic result_valid,
  input wire logic [127:0] result_value
);
  import psa_pkg::*;
  logic [127:0] d, s, add_v, sub_v, mul_v, shl_v, shr_v;
  logic [8:0] avg_v;
  logic go, sh;
  assign d = dst_reg_value;
  assign s = issue_src_is_mem ? src_mem_value : src_reg_value;
  assign add_v = {d[127:64] + s[127:64], d[63:0] + s[63:0]};
  assign sub_v = {d[127:64] - s[127:64], d[63:0] - s[63:0]};
  assign mul_v = {64'(d[95:64]) * s[95:64], 64'(d[31:0]) * s[31:0]};
  assign shl_v = d << {issue_imm[3:0], 3'h0};
  assign shr_v = d >> {issue_imm[3:0], 3'h0};
  assign avg_v = d[7:0] + s[7:0] + 9'h001;
  assign go = issue_valid && issue_wide;
  assign sh = issue_op == psa_op_byte_shift_left || issue_op == psa_op_byte_shift_right;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_sad; issue_valid && issue_op == psa_op_sum_abs_diff |=> result_value[63:16] == 48'h0; endproperty
  a_sad: assert property (p_sad) else $error("sum of differences upper words not zero");
  property p_avg; go && issue_op == psa_op_avg_byte |=> result_value[7:0] == $past(avg_v[8:1]); endproperty
  a_avg: assert property (p_avg) else $error("byte average wrong");
  property p_mul; go && issue_op == psa_op_dword_unsigned_widen_multiply |=> result_value == $past(mul_v); endproperty
  a_mul: assert property (p_mul) else $error("widening multiply wrong");
  property p_add; go && issue_op == psa_op_quad_lane_add |=> result_valid && result_value == $past(add_v); endproperty
  a_add: assert property (p_add) else $error("quad add wrong");
  property p_sub; go && issue_op == psa_op_quad_lane_subtract |=> result_value == $past(sub_v); endproperty
  a_sub: assert property (p_sub) else $error("quad subtract wrong");
  property p_narrow; issue_valid && !issue_wide && !sh |=> result_value[127:64] == 64'h0; endproperty
  a_narrow: assert property (p_narrow) else $error("narrow form upper half not zero");
  property p_big; issue_valid && sh && issue_imm > psa_shift_max_imm |=> result_value == 128'h0; endproperty
  a_big: assert property (p_big) else $error("large shift not zero");
  property p_shl;
    issue_valid && issue_op == psa_op_byte_shift_left && issue_imm <= psa_shift_max_imm |=> result_value == $past(shl_v);
  endproperty
  a_shl: assert property (p_shl) else $error("left byte shift wrong");
  property p_shr;
    issue_valid && issue_op == psa_op_byte_shift_right && issue_imm <= psa_shift_max_imm |=> result_value == $past(shr_v);
  endproperty
  a_shr: assert property (p_shr) else $error("right byte shift wrong");
  c_mem: cover property (issue_valid && issue_src_is_mem);
  c_big: cover property (issue_valid && sh && issue_imm > psa_shift_max_imm);
  c_b2b: cover property (issue_valid [*3]);
endmodule
bind psa_alu psa_alu_sva i_psa_alu_sva (.clock, .resetn, .issue_valid, .issue_op, .issue_wide, .issue_src_is_mem,
  .issue_imm, .dst_reg_value, .src_reg_value, .src_mem_value, .result_valid, .result_value);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the packed SIMD ALU
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import psa_pkg::*;
  typedef struct {psa_op_type op; logic [1:0] wm; logic [7:0] imm; logic [127:0] d, s, e;} psa_row_type;
  // wm: bit 1 selects the wide form, bit 0 the memory operand
  psa_row_type rows [11] = '{
    '{psa_op_sum_abs_diff, 2'h0, 8'h00, {64'h1, 64'h0a05}, 128'h0309, 128'h0b},
    '{psa_op_avg_byte, 2'h3, 8'h00, {16{8'hff}}, 128'h0, {16{8'h80}}},
    '{psa_op_avg_word, 2'h2, 8'h00, {16{8'hff}}, 128'h0, {8{16'h8000}}},
    '{psa_op_mul_add_pairs, 2'h0, 8'h00, 128'h0002_0003_ffff_0004, 128'h0005_0006_0002_0003, 128'h1c_0000_000a},
    '{psa_op_byte_shift_left, 2'h0, 8'h03, {8'haa, 120'h11}, 128'h0, 128'h11000000},
    '{psa_op_byte_shift_right, 2'h0, 8'h0f, {8'haa, 120'h11}, 128'h0, 128'haa},
    '{psa_op_byte_shift_right, 2'h2, 8'h10, {16{8'hff}}, 128'h0, 128'h0},
    '{psa_op_byte_shift_left, 2'h2, 8'h80, {16{8'hff}}, 128'h0, 128'h0},
    '{psa_op_dword_unsigned_widen_multiply, 2'h3, 8'h00, {64'h9_ffffffff, 64'h7_00000002},
      {64'h3_ffffffff, 64'h5_ffffffff}, {64'hfffffffe00000001, 64'h1fffffffe}},
    '{psa_op_quad_lane_add, 2'h3, 8'h00, {64'hffffffffffffffff, 64'h1}, {64'h2, 64'h3}, {64'h1, 64'h4}},
    '{psa_op_quad_lane_subtract, 2'h2, 8'h00, 128'h5, {64'h1, 64'h7}, {{127{1'b1}}, 1'b0}}};
  logic clock, resetn = 1'b0, issue_valid = 1'b0, issue_wide = 1'b0, issue_src_is_mem = 1'b0, result_valid;
  psa_op_type issue_op = psa_op_pass;
  logic [7:0] issue_imm = 8'h00;
  logic [127:0] dst_reg_value = 128'h0, operand = 128'h0, src_reg_value, src_mem_value, result_value;
  int err_count = 0, compares = 0;
  psa_pipe_model i_psa_pipe_model (.use_mem(issue_src_is_mem), .operand, .src_reg_value, .src_mem_value);
  psa_alu i_psa_alu (.clock, .resetn, .issue_valid, .issue_op, .issue_wide, .issue_src_is_mem, .issue_imm,
    .dst_reg_value, .src_reg_value, .src_mem_value, .result_valid, .result_value);
  task automatic chk(string n, logic [128:0] seen, logic [128:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #5000;
    err_count++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clock);
    chk("reset value", {result_valid, result_value}, 129'h0);
    resetn <= 1'b1;
    // Requests back to back; each result checked one edge later
    for (int i = 0; i <= 11; i++) begin
      @(posedge clock);
      issue_valid <= i < 11;
      if (i < 11) begin
        issue_op <= rows[i].op;
        {issue_wide, issue_src_is_mem} <= rows[i].wm;
        issue_imm <= rows[i].imm;
        dst_reg_value <= rows[i].d;
        operand <= rows[i].s;
      end
      #1;
      if (i > 0) chk("result", {result_valid, result_value},
        {1'b1, rows[i-1].e});
    end
    @(posedge clock);
    #1;
    chk("held", {result_valid, result_value}, {1'b0, rows[10].e});
    @(posedge clock);
    resetn <= 1'b0;
    #1;
    chk("mid reset", {result_valid, result_value}, 129'h0);
    @(posedge clock);
    resetn <= 1'b1;
    // After the second release: pass-through, wide then narrow back to back
    @(posedge clock);
    issue_valid <= 1'b1;
    issue_op <= psa_op_pass;
    issue_wide <= 1'b1;
    dst_reg_value <= {64'h0123456789abcdef, 64'hfedcba9876543210};
    @(posedge clock);
    issue_wide <= 1'b0;
    #1;
    chk("pass wide", {result_valid, result_value}, {1'b1, 64'h0123456789abcdef, 64'hfedcba9876543210});
    @(posedge clock);
    issue_valid <= 1'b0;
    #1;
    chk("pass narrow", {result_valid, result_value}, {1'b1, 64'h0, 64'hfedcba9876543210});
    stop_test;
  end
endmodule
`default_nettype wire
